/* design/smc_pkg.sv */
// Package of constants and types for the switch mode controller block.
package smc_pkg;

    localparam logic [11:0] TIMING_INDEX = 12'h111;
    localparam logic [11:0] MODE_INDEX = 12'h112;
    localparam logic [11:0] STATUS_INDEX = 12'h113;
    localparam logic [11:0] TIMING_ADDR = {TIMING_INDEX[9:0], 2'b00};
    localparam logic [11:0] MODE_ADDR = {MODE_INDEX[9:0], 2'b00};
    localparam logic [11:0] STATUS_ADDR = {STATUS_INDEX[9:0], 2'b00};

    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] MODE_IMPL_MASK = 8'hef;

    // Duties are expressed in 32nds of the switching period.
    localparam int DUTY_LOG2 = 5;
    localparam logic [5:0] HALF_DUTY = 6'h10;
    localparam logic [5:0] MAX_DUTY [4] = '{6'h10, 6'h14, 6'h18, 6'h1e};
    // Log2 of the oscillator divide for Fosc/128, /64, /32 and /16.
    localparam logic [2:0] PERIOD_LOG2 [4] = '{3'h7, 3'h6, 3'h5, 3'h4};

    typedef struct packed {
        logic [1:0] clk_prescale;
        logic [1:0] min_duty;
        logic [1:0] max_duty;
        logic [1:0] duty_step;
    } timing_t;

    typedef struct packed {
        logic ctrl_enable_bit;
        logic out_a_polarity;
        logic out_b_polarity;
        logic unused;
        logic slope_comp_enable;
        logic dual_output_select;
        logic width_or_skip_select;
        logic feedback_input_select;
    } mode_t;

    typedef struct packed {
        logic [1:0] reserved;
        logic sleeping;
        logic out_b_drive;
        logic out_a_drive;
        logic skip;
        logic trip;
        logic phase;
    } status_t;

endpackage

/* design/switch_period_counter.sv */
// Switching period counter driven by the main oscillator.
`timescale 1ns/100ps
module switch_period_counter
    import smc_pkg::*;
#(
    parameter int CW = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] period_log2,
    output logic [CW-1:0] count,
    output logic period_end
);

    logic [CW:0] span;
    logic [CW-1:0] period_max;

    assign span = (CW+1)'(1) << period_log2;
    assign period_max = CW'(span - (CW+1)'(1));
    assign period_end = run && (count >= period_max);

    // The count freezes while not running unless restart clears it, so a sleep keeps the phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (restart) begin
            count <= '0;
        end else if (period_end) begin
            count <= '0;
        end else if (run) begin
            count <= count + CW'(1);
        end
    end

endmodule

/* design/switch_mode_ctrl.sv */
// Switch mode controller: APB registers, pulse engine and output pins.
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
module switch_mode_ctrl
    import smc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_mode,
    input wire logic feedback_c1,
    input wire logic feedback_c2,
    output logic switch_out_a,
    output logic switch_out_a_oe,
    output logic switch_out_b,
    output logic switch_out_b_oe
);

    timing_t timing;
    mode_t mode;
    status_t status;
    logic [6:0] count;
    logic period_end;
    logic run;
    logic restart;
    logic [2:0] period_log2;
    logic [5:0] min_thr;
    logic [5:0] max_thr;
    logic past_min;
    logic past_max;
    logic past_half;
    logic phase;
    logic trip_latched;
    logic skip;
    logic trip_now;
    logic drive_raw;
    logic drive_a;
    logic drive_b;
    logic slope_gate;
    logic pwm_active;
    logic fb_dual;
    logic access;
    logic setup;
    logic reg_write;
    logic mapped;
    logic [31:0] next_prdata;

    // Register bus slave.

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = access;
    assign mapped = (paddr == TIMING_ADDR) || (paddr == MODE_ADDR) ||
                    (paddr == STATUS_ADDR);
    assign pslverr = access && !mapped;
    assign reg_write = access && pwrite && mapped && pstrb[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timing <= TIMING_RESET;
        end else if (reg_write && paddr == TIMING_ADDR) begin
            timing <= pwdata[7:0];
        end
    end

    // Bit 4 is not stored, so it always reads back as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= MODE_RESET;
        end else if (reg_write && paddr == MODE_ADDR) begin
            mode <= pwdata[7:0] & MODE_IMPL_MASK;
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (paddr == TIMING_ADDR) begin
            next_prdata[7:0] = timing;
        end else if (paddr == MODE_ADDR) begin
            next_prdata[7:0] = mode & MODE_IMPL_MASK;
        end else if (paddr == STATUS_ADDR) begin
            next_prdata[7:0] = status;
        end
    end

    // Read data is captured in the setup cycle and held through access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // Timing decode and period counter.

    // The controller only advances while enabled and the oscillator runs.
    assign run = mode.ctrl_enable_bit && !sleep_mode;
    assign restart = !mode.ctrl_enable_bit;
    assign period_log2 = PERIOD_LOG2[timing.clk_prescale];
    assign min_thr = {2'b00, timing.min_duty, timing.duty_step};
    assign max_thr = MAX_DUTY[timing.max_duty];
    assign pwm_active = mode.width_or_skip_select;
    assign fb_dual = mode.feedback_input_select;

    switch_period_counter #(
        .CW(7)
    ) u_period (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .restart(restart),
        .period_log2(period_log2),
        .count(count),
        .period_end(period_end)
    );

    // True once the count has reached thr/32 of the period.
    function automatic logic reached(input logic [6:0] cnt,
                                     input logic [5:0] thr,
                                     input logic [2:0] lg);
        logic [12:0] scaled_cnt;
        logic [12:0] scaled_thr;
        scaled_cnt = {1'b0, cnt, 5'h00};
        scaled_thr = 13'(thr) << lg;
        return scaled_cnt >= scaled_thr;
    endfunction

    assign past_min = reached(count, min_thr, period_log2);
    assign past_max = reached(count, max_thr, period_log2);
    assign past_half = reached(count, HALF_DUTY, period_log2);

    // Pulse engine.

    assign trip_now = (fb_dual && phase) ? feedback_c2 : feedback_c1;

    // Pulse is on below the minimum, never at or past the maximum, and
    // between them only until the comparator trips or a skip is pending.
    always_comb begin
        drive_raw = 1'b0;
        if (mode.ctrl_enable_bit && !past_max) begin
            if (!past_min) begin
                drive_raw = 1'b1;
            end else if (pwm_active) begin
                drive_raw = !trip_latched && !trip_now;
            end else begin
                drive_raw = !skip;
            end
        end
    end

    // A trip during the pulse holds it off until the period ends.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_latched <= 1'b0;
        end else if (restart || period_end) begin
            trip_latched <= 1'b0;
        end else if (run && past_min && trip_now) begin
            trip_latched <= 1'b1;
        end
    end

    // In skip mode a comparator high at the period end skips the next one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip <= 1'b0;
        end else if (restart) begin
            skip <= 1'b0;
        end else if (period_end) begin
            skip <= trip_now;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 1'b0;
        end else if (restart || !mode.dual_output_select) begin
            phase <= 1'b0;
        end else if (period_end) begin
            phase <= !phase;
        end
    end

    // Slope compensation ramp gate on the second pin in single mode.
    assign slope_gate = mode.ctrl_enable_bit && past_half;
    assign drive_a = drive_raw && !(mode.dual_output_select && phase);
    assign drive_b = mode.dual_output_select ? (drive_raw && phase) :
                     (mode.slope_comp_enable && slope_gate);

    // Output pins.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_out_a_oe <= 1'b0;
            switch_out_b_oe <= 1'b0;
        end else begin
            switch_out_a_oe <= mode.ctrl_enable_bit;
            switch_out_b_oe <= mode.ctrl_enable_bit &&
                (mode.dual_output_select || mode.slope_comp_enable);
        end
    end

    // Sleep forces each pin to its inactive level for its polarity.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_out_a <= 1'b0;
            switch_out_b <= 1'b0;
        end else if (sleep_mode) begin
            switch_out_a <= mode.out_a_polarity;
            switch_out_b <= mode.out_b_polarity;
        end else begin
            switch_out_a <= drive_a ^ mode.out_a_polarity;
            switch_out_b <= drive_b ^ mode.out_b_polarity;
        end
    end

    always_comb begin
        status = '0;
        status.phase = phase;
        status.trip = trip_latched;
        status.skip = skip;
        status.out_a_drive = drive_a;
        status.out_b_drive = drive_b;
        status.sleeping = sleep_mode;
    end

    // Checks.

    // Two low samples, so the very first edge cannot see unreset flops.
    a_reset_regs_zero: assert property (
        @(posedge pclk) !presetn ##1 !presetn |->
        (timing == 8'h00 && mode == 8'h00))
        else $error("control registers not zero under reset");

    a_reset_pins_hiz: assert property (
        @(posedge pclk) !presetn ##1 !presetn |->
        (!switch_out_a_oe && !switch_out_b_oe))
        else $error("output pins driven under reset");

    a_disabled_hiz: assert property (
        @(posedge pclk) disable iff (!presetn)
        !mode.ctrl_enable_bit |=> (!switch_out_a_oe && !switch_out_b_oe))
        else $error("output pins driven while controller disabled");

    a_enable_drives: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(mode.ctrl_enable_bit) |=> switch_out_a_oe &&
        !$past(switch_out_a_oe))
        else $error("pin A not driven one cycle after enable");

    a_sleep_freeze: assert property (
        @(posedge pclk) disable iff (!presetn)
        sleep_mode && !reg_write |=> $stable(count) && $stable(phase))
        else $error("period timing advanced during sleep");

    a_sleep_inactive: assert property (
        @(posedge pclk) disable iff (!presetn)
        sleep_mode |=> (switch_out_a == $past(mode.out_a_polarity) &&
                        switch_out_b == $past(mode.out_b_polarity)))
        else $error("output not at inactive level in sleep");

    a_wake_config: assert property (
        @(posedge pclk) disable iff (!presetn)
        sleep_mode && !reg_write |=> $stable(timing) && $stable(mode))
        else $error("configuration changed across sleep");

    a_fosc16_max94: assert property (
        @(posedge pclk) disable iff (!presetn)
        timing == 8'hcc && run |->
        (period_end == (count == 7'h0f)) && (past_max == (count == 7'h0f)))
        else $error("11001100 not giving 16-cycle period and 94 percent");

    a_fosc128_max50: assert property (
        @(posedge pclk) disable iff (!presetn)
        timing == 8'h00 && run |->
        (period_end == (count == 7'h7f)) && (past_max == (count >= 7'h40))
        && past_min)
        else $error("zero timing not giving 128-cycle period and 50 percent");

    a_mode_dual: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode == 8'h86 ##1 mode == 8'h86 |->
        switch_out_b_oe && pwm_active && !fb_dual)
        else $error("00000110 not giving PWM with two outputs");

    a_mode_single: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode == 8'h82 ##1 mode == 8'h82 |-> !switch_out_b_oe && !drive_b)
        else $error("00000010 not giving single output");

    a_bit4_reads_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && !pwrite && paddr == MODE_ADDR |-> prdata[4] == 1'b0)
        else $error("unimplemented mode bit read as one");

    a_trip_ends_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        run && pwm_active && past_min && trip_now && !period_end
        |=> !drive_raw)
        else $error("pulse not ended after comparator trip");

    a_dual_alternate: assert property (
        @(posedge pclk) disable iff (!presetn)
        run && period_end && mode.dual_output_select
        |=> phase != $past(phase))
        else $error("dual outputs did not alternate");

    a_duty_clamp: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode.ctrl_enable_bit |->
        (past_max -> !drive_raw) && ((!past_min && !past_max) -> drive_raw))
        else $error("duty outside minimum and maximum limits");

    c_trip_cut: cover property (
        @(posedge pclk) disable iff (!presetn)
        run && pwm_active && drive_raw ##1 trip_latched && !past_max);

    c_dual_toggle: cover property (
        @(posedge pclk) disable iff (!presetn)
        mode.dual_output_select && period_end ##1 phase);

    c_sleep_wake: cover property (
        @(posedge pclk) disable iff (!presetn)
        run && drive_raw ##1 sleep_mode [*3] ##1 !sleep_mode);

    c_skip_period: cover property (
        @(posedge pclk) disable iff (!presetn)
        !pwm_active && skip && run && past_min);

endmodule

/* verification/fb_model.sv */
// Feedback comparator model that trips after a set on-time of the pins.
`timescale 1ns/100ps
module fb_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic drive_a,
    input wire logic drive_b,
    input wire logic [7:0] trip_at,
    output logic fb_c1,
    output logic fb_c2
);
    int run;

    // A trip time of zero trips at once; all ones never trips.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 0;
        end else begin
            run <= (drive_a || drive_b) ? run + 1 : 0;
        end
    end

    assign fb_c1 = trip_at == 8'h00 ||
                   (trip_at != 8'hff && run >= trip_at);
    assign fb_c2 = fb_c1;
endmodule

/* verification/switch_mode_ctrl_config_sleep_reset_tb_top.sv */
// Testbench for the switch mode controller with APB tasks and a pin model.
`timescale 1ns/100ps
module switch_mode_ctrl_config_sleep_reset_tb_top
    import smc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, sleep_mode, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic fb_c1, fb_c2, err;
    logic switch_out_a, switch_out_a_oe, switch_out_b, switch_out_b_oe;
    logic [7:0] trip_at, m_timing, m_mode;
    int n_fail, samples_checked, cyc, ha, hb, seed, v;
    int mx[4] = '{16, 20, 24, 30};

    switch_mode_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_mode(sleep_mode), .feedback_c1(fb_c1), .feedback_c2(fb_c2),
        .switch_out_a(switch_out_a), .switch_out_a_oe(switch_out_a_oe),
        .switch_out_b(switch_out_b), .switch_out_b_oe(switch_out_b_oe));

    fb_model u_fb (.pclk(pclk), .presetn(presetn),
        .drive_a(switch_out_a & switch_out_a_oe),
        .drive_b(switch_out_b & switch_out_b_oe), .trip_at(trip_at),
        .fb_c1(fb_c1), .fb_c2(fb_c2));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task final_report();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [7:0] d,
             input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s);
        if (s[0] && a == TIMING_ADDR) m_timing = d;
        if (s[0] && a == MODE_ADDR) m_mode = d & 8'hef;
    endtask

    task rdc(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, 4'hf);
        chk(rd, {24'h0, exp});
    endtask

    // The controller is disabled before its fields change, enabled last.
    task cfg(input logic [7:0] t, input logic [7:0] md);
        wr(MODE_ADDR, md & 8'h7f, 4'h1);
        wr(TIMING_ADDR, t, 4'h1);
        wr(MODE_ADDR, md, 4'h1);
        repeat (4) @(posedge pclk);
        chk({31'h0, switch_out_a_oe}, {31'h0, md[7]});
    endtask

    task meas(input int c);
        ha = 0;
        hb = 0;
        repeat (c) @(posedge pclk) begin
            ha += (switch_out_a === 1'b1);
            hb += (switch_out_b === 1'b1);
        end
    endtask

    function int on_cyc(input logic [7:0] t, input bit tripped);
        int n, lim;
        n = 128 >> t[7:6];
        lim = tripped ? {t[5:4], t[1:0]} : mx[t[3:2]];
        return (lim * n + 31) / 32;
    endfunction

    initial begin
        seed = 8;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        sleep_mode = 1'b0;
        trip_at = 8'hff;
        m_timing = 8'h00;
        m_mode = 8'h00;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(TIMING_ADDR, 8'h00);
        rdc(MODE_ADDR, 8'h00);
        apb(1'b0, 12'h000, 8'h00, 4'hf);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            wr(TIMING_ADDR, v[7:0], {3'b000, v[8]});
            rdc(TIMING_ADDR, m_timing);
            wr(MODE_ADDR, v[23:16] & 8'h7f, 4'h1);
            rdc(MODE_ADDR, m_mode);
            chk({30'h0, switch_out_a_oe, switch_out_b_oe}, 32'h0);
        end
        cfg(8'hcc, 8'h92);
        rdc(MODE_ADDR, 8'h82);
        meas(64);
        chk(ha, 4 * on_cyc(8'hcc, 1'b0));
        chk(hb, 0);
        chk({31'h0, switch_out_b_oe}, 32'h0);
        trip_at <= 8'h03;
        meas(64);
        chk({31'h0, ha > 0 && ha < 60}, 32'h1);
        trip_at <= 8'h00;
        cfg(8'hfc, 8'h82);
        meas(64);
        chk(ha, 4 * on_cyc(8'hfc, 1'b1));
        trip_at <= 8'hff;
        cfg(8'h00, 8'h82);
        meas(256);
        chk(ha, 2 * on_cyc(8'h00, 1'b0));
        cfg(8'h00, 8'h86);
        chk({31'h0, switch_out_b_oe}, 32'h1);
        meas(512);
        chk(ha, 2 * on_cyc(8'h00, 1'b0));
        chk(hb, 2 * on_cyc(8'h00, 1'b0));
        // Pulse-skip mode with slope compensation on the second pin.
        cfg(8'hcc, 8'h88);
        meas(64);
        chk(ha, 4 * on_cyc(8'hcc, 1'b0));
        chk(hb, 64 * HALF_DUTY / 32);
        trip_at <= 8'h00;
        repeat (20) @(posedge pclk);
        meas(64);
        chk(ha, 0);
        trip_at <= 8'hff;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({30'h0, switch_out_a_oe, switch_out_b_oe}, 32'h0);
        presetn <= 1'b1;
        m_timing = 8'h00;
        m_mode = 8'h00;
        rdc(TIMING_ADDR, 8'h00);
        rdc(MODE_ADDR, 8'h00);
        cfg(8'hcc, 8'hc2);
        meas(64);
        chk(64 - ha, 4 * on_cyc(8'hcc, 1'b0));
        sleep_mode <= 1'b1;
        repeat (2) @(posedge pclk);
        meas(20);
        chk(ha, 20);
        apb(1'b0, STATUS_ADDR, 8'h00, 4'hf);
        chk({31'h0, rd[5]}, 32'h1);
        sleep_mode <= 1'b0;
        repeat (2) @(posedge pclk);
        meas(64);
        chk(64 - ha, 4 * on_cyc(8'hcc, 1'b0));
        final_report();
    end
endmodule
